// *** tws_pkg.sv ***
// constants and types shared by the two-wire eeprom slave port
`default_nettype none
package tws_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int MEM_DEPTH = 128;
    localparam int PAGE_BYTES = 4;
    localparam int BUF_DEPTH = 2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] MEM_RESET = 8'hff;
    localparam logic [1:0] LINE_RESET = 2'h3;
    localparam logic WP_RESET = 1'b0;
    localparam int WRITE_TIME_MS = 10;
    localparam int CLK_PERIOD_NS = 4;
    localparam int WRITE_CYCLES_DEF = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        TWS_IDLE,
        TWS_ADDR,
        TWS_ADDR_ACK,
        TWS_WDATA,
        TWS_WACK,
        TWS_RDATA,
        TWS_RACK
    } tws_state_t;
endpackage
`default_nettype wire

// *** tws_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module tws_sync
    import tws_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    generate
        if (WIDTH < 1)
        begin : g_chk
            $error("tws_sync needs WIDTH of one or more");
        end
    endgenerate

    always_comb
    begin
        meta_d = d_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

// *** tws_buf.sv ***
// small valid/ready buffer for received write bytes
`timescale 1ns/10ps
`default_nettype none
module tws_buf
    import tws_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = BUF_DEPTH
)(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_chk
            $error("tws_buf needs a power of two DEPTH of two or more");
        end
    endgenerate

    assign in_ready_o = (cnt_q != CW'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb
    begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = in_data_i;
            wr_d = wr_q + PW'(1);
        end
        if (pop)
        begin
            rd_d = rd_q + PW'(1);
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + CW'(1);
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // data out of flops; read pointer picks the oldest entry
    assign out_data_o = mem_q[rd_q];
endmodule
`default_nettype wire

// *** tws_slave.sv ***
// two-wire eeprom slave port with array, page latch and write cycle timer
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - start is data falling while clock high; opens every transfer
// - outside programming, watch for start; stay silent until one arrives
// - stop is data rising while clock high; ends the transfer
// - stop after a read returns to standby
// - stop after a write starts the self-timed write cycle
// - transmitter releases data line after eight data bits
// - receiver pulls data low on ninth pulse; device acks written bytes
// - device samples data on each rising clock edge while receiving
// - write-protect input high protects, low unprotects
// - unconnected write-protect input counts as low
// - internal reset blocks all operations and answers
// - device is only a slave; never drives clock or starts
// - address bits and read/write bit share one byte after start
// - array holds 128 bytes of eight bits
// - page write accepts up to four bytes per write cycle
// - data line driven only as open drain
// - address byte msb first: seven address bits then read/write, one is read
// - page write increments two low address bits; wraps within row
// - write protected between start and address end: no change, no data ack
// - during programming all bus inputs ignored, nothing answered
module tws_slave
    import tws_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
)(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_b_o,
    input wire logic write_protect_input_i,
    output logic write_busy_o
);
    localparam int BCW = $clog2(WRITE_CYCLES + 1);

    generate
        if (WRITE_CYCLES < 2)
        begin : g_chk
            $error("tws_slave needs WRITE_CYCLES of two or more");
        end
    endgenerate

    logic [1:0] line_s;
    logic wp_s;
    logic scl_s, sda_s, scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, start, stop;

    // reset itself is the supply lockout: nothing answers while held
    tws_sync #(.WIDTH(2), .RESET_VAL(LINE_RESET)) u_line_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i({scl_i, sda_i}),
        .q_o(line_s)
    );

    // protect level only; a floating pin is pulled low outside
    tws_sync #(.WIDTH(1), .RESET_VAL(WP_RESET)) u_wp_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(write_protect_input_i),
        .q_o(wp_s)
    );

    assign scl_s = line_s[1];
    assign sda_s = line_s[0];

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            scl_p_q <= LINE_RESET[1];
            sda_p_q <= LINE_RESET[0];
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;

    tws_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic rw_q, rw_d, wp_lat_q, wp_lat_d, drive_q, drive_d;
    logic wcmd_q, wcmd_d, macked_q, macked_d;
    logic push, addr_take;
    logic buf_in_ready, buf_out_valid, buf_out_ready, pop;
    logic [DATA_W-1:0] buf_out_data;
    logic busy_q, busy_d, commit;
    logic [BCW-1:0] bcnt_q, bcnt_d;
    logic [DATA_W-1:0] latch_q [PAGE_BYTES];
    logic [DATA_W-1:0] latch_d [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q, mask_d;
    logic [1:0] waddr_q, waddr_d;
    logic [DATA_W-1:0] mem_q [MEM_DEPTH];
    logic [DATA_W-1:0] mem_d [MEM_DEPTH];

    // bus state machine; device only follows the master's clock
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        addr_d = addr_q;
        rw_d = rw_q;
        wp_lat_d = wp_lat_q;
        drive_d = drive_q;
        wcmd_d = wcmd_q;
        macked_d = macked_q;
        push = 1'b0;
        addr_take = 1'b0;
        if (busy_q)
        begin
            state_d = TWS_IDLE;
            drive_d = 1'b0;
        end
        else if (start)
        begin
            state_d = TWS_ADDR;
            cnt_d = 4'h0;
            drive_d = 1'b0;
            wp_lat_d = wp_s;
            wcmd_d = 1'b0;
        end
        else if (stop)
        begin
            state_d = TWS_IDLE;
            drive_d = 1'b0;
        end
        else
        begin
            if (wp_s && state_q == TWS_ADDR)
            begin
                wp_lat_d = 1'b1;
            end
            // inputs settle while clock low, so the rising edge is safe
            if (scl_rise)
            begin
                case (state_q)
                    TWS_ADDR, TWS_WDATA:
                    begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end
                    TWS_RDATA:
                    begin
                        cnt_d = cnt_q + 4'h1;
                    end
                    TWS_RACK:
                    begin
                        macked_d = !sda_s;
                    end
                    default:
                    begin
                    end
                endcase
            end
            if (scl_fall)
            begin
                case (state_q)
                    TWS_ADDR:
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            addr_d = shift_q[7:1];
                            rw_d = shift_q[0];
                            addr_take = 1'b1;
                            state_d = TWS_ADDR_ACK;
                            drive_d = 1'b1;
                        end
                    end
                    TWS_ADDR_ACK:
                    begin
                        cnt_d = 4'h0;
                        if (rw_q)
                        begin
                            shift_d = mem_q[addr_q];
                            drive_d = !mem_q[addr_q][7];
                            state_d = TWS_RDATA;
                        end
                        else
                        begin
                            drive_d = 1'b0;
                            wcmd_d = 1'b1;
                            state_d = TWS_WDATA;
                        end
                    end
                    TWS_WDATA:
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            state_d = TWS_WACK;
                            // a full buffer refuses the byte and shows as no ack
                            if (!wp_lat_q && buf_in_ready)
                            begin
                                push = 1'b1;
                                drive_d = 1'b1;
                            end
                            else
                            begin
                                drive_d = 1'b0;
                            end
                        end
                    end
                    TWS_WACK:
                    begin
                        cnt_d = 4'h0;
                        drive_d = 1'b0;
                        state_d = TWS_WDATA;
                    end
                    TWS_RDATA:
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            drive_d = 1'b0;
                            state_d = TWS_RACK;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'b0};
                            drive_d = !shift_q[6];
                        end
                    end
                    TWS_RACK:
                    begin
                        cnt_d = 4'h0;
                        if (macked_q)
                        begin
                            addr_d = addr_q + 7'h01;
                            shift_d = mem_q[addr_q + 7'h01];
                            drive_d = !mem_q[addr_q + 7'h01][7];
                            state_d = TWS_RDATA;
                        end
                        else
                        begin
                            state_d = TWS_IDLE;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= TWS_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            addr_q <= 7'h00;
            rw_q <= 1'b0;
            wp_lat_q <= 1'b0;
            drive_q <= 1'b0;
            wcmd_q <= 1'b0;
            macked_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            rw_q <= rw_d;
            wp_lat_q <= wp_lat_d;
            drive_q <= drive_d;
            wcmd_q <= wcmd_d;
            macked_q <= macked_d;
        end
    end

    // decouples byte capture from the latch; no byte lost on a stall
    tws_buf #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_wbuf (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(push),
        .in_ready_o(buf_in_ready),
        .in_data_i(shift_q),
        .out_valid_o(buf_out_valid),
        .out_ready_i(buf_out_ready),
        .out_data_o(buf_out_data)
    );

    assign buf_out_ready = !busy_q;
    assign pop = buf_out_valid && buf_out_ready;

    // write cycle timer
    always_comb
    begin
        busy_d = busy_q;
        bcnt_d = bcnt_q;
        if (busy_q)
        begin
            bcnt_d = bcnt_q - BCW'(1);
            if (bcnt_q == BCW'(1))
            begin
                busy_d = 1'b0;
            end
        end
        else if (stop && wcmd_q && (mask_q != '0 || pop))
        begin
            busy_d = 1'b1;
            bcnt_d = BCW'(WRITE_CYCLES);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            busy_q <= 1'b0;
            bcnt_q <= '0;
        end
        else
        begin
            busy_q <= busy_d;
            bcnt_q <= bcnt_d;
        end
    end

    assign commit = busy_q && (bcnt_q == BCW'(1));

    // page latch; only the two low address bits advance
    always_comb
    begin
        latch_d = latch_q;
        mask_d = mask_q;
        waddr_d = waddr_q;
        if (start && !busy_q)
        begin
            mask_d = '0;
        end
        if (addr_take)
        begin
            waddr_d = shift_q[2:1];
        end
        if (pop)
        begin
            latch_d[waddr_q] = buf_out_data;
            mask_d[waddr_q] = 1'b1;
            waddr_d = waddr_q + 2'h1;
        end
        if (commit)
        begin
            mask_d = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                latch_q[i] <= 8'h00;
            end
            mask_q <= '0;
            waddr_q <= 2'h0;
        end
        else
        begin
            latch_q <= latch_d;
            mask_q <= mask_d;
            waddr_q <= waddr_d;
        end
    end

    // array of 128 bytes, updated only when the write cycle ends
    always_comb
    begin
        mem_d = mem_q;
        if (commit)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                if (mask_q[i])
                begin
                    mem_d[{addr_q[6:2], 2'(i)}] = latch_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < MEM_DEPTH; i++)
            begin
                mem_q[i] <= MEM_RESET;
            end
        end
        else
        begin
            mem_q <= mem_d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_b_o = !drive_q;
    assign write_busy_o = busy_q;

    property p_start_opens;
        @(posedge clk_i) disable iff (!rst_b_i) start && !busy_q |=> state_q == TWS_ADDR;
    endproperty
    a_start_opens: assert property (p_start_opens)
        else $error("start did not open address phase");

    property p_stop_read_idle;
        @(posedge clk_i) disable iff (!rst_b_i)
            stop && !busy_q && !wcmd_q |=> state_q == TWS_IDLE && !busy_q;
    endproperty
    a_stop_read_idle: assert property (p_stop_read_idle)
        else $error("stop after read did not return to standby");

    property p_stop_write_busy;
        @(posedge clk_i) disable iff (!rst_b_i)
            stop && !busy_q && wcmd_q && mask_q != '0 |=> busy_q;
    endproperty
    a_stop_write_busy: assert property (p_stop_write_busy)
        else $error("stop after write did not start write cycle");

    property p_busy_silent;
        @(posedge clk_i) disable iff (!rst_b_i)
            busy_q ##1 busy_q |-> sda_oe_b_o && state_q == TWS_IDLE;
    endproperty
    a_busy_silent: assert property (p_busy_silent)
        else $error("device answered during write cycle");

    property p_addr_ack;
        @(posedge clk_i) disable iff (!rst_b_i)
            scl_fall && !busy_q && !start && !stop && state_q == TWS_ADDR
            && cnt_q == BITS_PER_BYTE |=> !sda_oe_b_o && state_q == TWS_ADDR_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address byte not acknowledged");

    property p_protect_nack;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_q == TWS_WACK && wp_lat_q |-> sda_oe_b_o && !push;
    endproperty
    a_protect_nack: assert property (p_protect_nack)
        else $error("protected data byte was acknowledged");

    property p_release_after_byte;
        @(posedge clk_i) disable iff (!rst_b_i)
            state_q == TWS_RACK || state_q == TWS_IDLE |-> sda_oe_b_o;
    endproperty
    a_release_after_byte: assert property (p_release_after_byte)
        else $error("data line held after byte or in idle");

    property p_open_drain;
        @(posedge clk_i) disable iff (!rst_b_i) !sda_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data line driven high");

    property p_sample_rise;
        @(posedge clk_i) disable iff (!rst_b_i)
            scl_rise && !busy_q && !start && !stop && state_q == TWS_WDATA
            |=> shift_q[0] == $past(sda_s);
    endproperty
    a_sample_rise: assert property (p_sample_rise)
        else $error("bit not sampled on rising clock");

    property p_row_kept;
        @(posedge clk_i) disable iff (!rst_b_i)
            pop |=> waddr_q == $past(waddr_q) + 2'h1 && $stable(addr_q[6:2]);
    endproperty
    a_row_kept: assert property (p_row_kept)
        else $error("page address left its row");

    c_write_ack: cover property (@(posedge clk_i) disable iff (!rst_b_i) push);
    c_read_more: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        state_q == TWS_RACK ##1 state_q == TWS_RDATA);
    c_busy_end: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(busy_q));
endmodule
`default_nettype wire

// *** tws_master_model.sv ***
// behavioural two-wire bus master for the slave port bench
`timescale 1ns/10ps
`default_nettype none
module tws_master_model #(
    parameter real QTR_NS = 31.25
)(
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // master owns the clock; frames open with start_cond or, without a start, with clock_low
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic start_cond();
        sda_o = 1'b1;
        #(QTR_NS);
        scl_o = 1'b1;
        #(QTR_NS);
        sda_o = 1'b0;
        #(QTR_NS);
        scl_o = 1'b0;
    endtask
    task automatic stop_cond();
        #(QTR_NS);
        sda_o = 1'b0;
        #(QTR_NS);
        scl_o = 1'b1;
        #(QTR_NS);
        sda_o = 1'b1;
        #(QTR_NS);
    endtask
    task automatic clock_low();
        #(QTR_NS);
        scl_o = 1'b0;
    endtask
    task automatic clock_bit(input logic b, output logic seen);
        #(QTR_NS);
        sda_o = b; // only with clock low
        #(QTR_NS);
        scl_o = 1'b1;
        #(QTR_NS);
        seen = sda_i;
        #(QTR_NS);
        scl_o = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(b[i], s); // msb first
        clock_bit(1'b1, ack);
    endtask
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'b1, s);
            b[i] = s;
        end
        clock_bit(nack, s);
    endtask
endmodule
`default_nettype wire

// *** two_wire_eeprom_slave_port_tb_top.sv ***
// self-checking bench for the two-wire eeprom slave port
`timescale 1ns/10ps
`default_nettype none
module two_wire_eeprom_slave_port_tb_top
    import tws_pkg::*;
;
    // short write cycle, still long enough to probe it mid-run
    localparam int WR_CYC = 600;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wp_i = 1'b0;
    logic m_scl, m_sda, sda_line, sda_dut, sda_oe_b, busy;
    logic [7:0] mem_m [MEM_DEPTH];
    logic [31:0] rnd = 32'h0af43090;
    logic [6:0] a0;
    int n_fail = 0;
    int total_checks = 0;
    int busy_len = 0;
    always #(CLK_PERIOD_NS / 2.0) clk_i = ~clk_i;
    assign sda_line = m_sda & (sda_oe_b | sda_dut); // pull-up wired and
    tws_slave #(.WRITE_CYCLES(WR_CYC)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(m_scl),
        .sda_i(sda_line), .sda_o(sda_dut), .sda_oe_b_o(sda_oe_b),
        .write_protect_input_i(wp_i), .write_busy_o(busy));
    tws_master_model mst (.sda_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        if (busy === 1'b1 && rst_b_i)
            busy_len <= busy_len + 1;
        else if (busy_len != 0)
        begin
            chk_bit("write cycle length", 1'b1, busy_len == WR_CYC);
            busy_len <= 0;
        end
    end
    task automatic probe(input logic with_start);
        logic ack;
        if (with_start)
            mst.start_cond();
        else
            mst.clock_low();
        mst.send_byte(8'h00, ack);
        chk_bit("unanswered ack", 1'b1, ack);
        mst.stop_cond();
    endtask
    task automatic write_page(input logic [6:0] a, input int n, input logic prot,
        input logic late);
        logic ack;
        if (!late)
            @(posedge clk_i) wp_i <= prot;
        mst.start_cond();
        // late protect lands inside the address byte
        if (late)
            @(posedge clk_i) wp_i <= prot;
        mst.send_byte({a, 1'b0}, ack);
        chk_bit("address ack", 1'b0, ack);
        for (int k = 0; k < n; k++)
        begin
            rnd = xs(rnd);
            mst.send_byte(rnd[7:0], ack);
            chk_bit("data ack", prot, ack);
            if (!prot)
                mem_m[a] = rnd[7:0];
            a = {a[6:2], a[1:0] + 2'h1}; // row wrap
        end
        mst.stop_cond();
        repeat (8) @(posedge clk_i);
        chk_bit("busy after stop", !prot && n > 0, busy);
        wp_i <= 1'b0;
    endtask
    task automatic wait_idle();
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 2 * WR_CYC)
        begin
            @(posedge clk_i);
            t++;
        end
        chk_bit("write cycle ends", 1'b0, busy);
        repeat (4) @(posedge clk_i);
    endtask
    task automatic read_seq(input logic [6:0] a, input int n);
        logic ack;
        logic [7:0] d;
        mst.start_cond();
        mst.send_byte({a, 1'b1}, ack);
        chk_bit("read address ack", 1'b0, ack);
        for (int k = 0; k < n; k++)
        begin
            mst.recv_byte(k == n - 1, d);
            chk_byte("read data", mem_m[a], d);
            a = a + 7'h01;
        end
        mst.stop_cond();
        repeat (4) @(posedge clk_i);
        chk_bit("standby busy", 1'b0, busy);
        chk_bit("line released", 1'b1, sda_oe_b);
    endtask
    initial
    begin
        for (int i = 0; i < MEM_DEPTH; i++)
            mem_m[i] = MEM_RESET;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk_bit("released after reset", 1'b1, sda_oe_b);
        probe(1'b0);
        write_page(7'h7e, 5, 1'b0, 1'b0);
        probe(1'b1);
        wait_idle();
        read_seq(7'h7c, 6);
        write_page(7'h11, 2, 1'b1, 1'b1);
        wait_idle();
        read_seq(7'h10, 4);
        for (int r = 0; r < 6; r++)
        begin
            rnd = xs(rnd);
            a0 = rnd[6:0];
            write_page(a0, int'(rnd[9:8]) + 1, rnd[12], rnd[13]);
            wait_idle();
            read_seq({a0[6:2], 2'h0}, 4);
        end
        @(posedge clk_i) rst_b_i <= 1'b0;
        probe(1'b1);
        @(posedge clk_i) rst_b_i <= 1'b1;
        for (int i = 0; i < MEM_DEPTH; i++)
            mem_m[i] = MEM_RESET;
        repeat (4) @(posedge clk_i);
        read_seq(a0, 3);
        complete_run();
    end
    initial
    begin
        #300000;
        n_fail++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
`default_nettype wire
